// ===== src/sps_pkg.sv
// shared constants, register map and carrier types of the stepper sequencer
`default_nettype none
package sps_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TOFF   = 8'h08;
	// control field positions
	localparam int CTRL_HALF  = 0;
	localparam int CTRL_CW    = 1;
	localparam int CTRL_SLOW  = 2;
	localparam int CTRL_EN    = 3;
	localparam int CTRL_RUN   = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int TOFF_NS       = 20_000;
	localparam int TOFF_CYC      = (TOFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int TOFF_W        = 16;
	localparam logic [TOFF_W-1:0] TOFF_RESET = TOFF_CYC[TOFF_W-1:0];
	// phase state numbering: index 0 is state 1
	localparam logic [2:0] STATE_FIRST = 3'h0;
	localparam logic [2:0] STEP_HALF   = 3'h1;
	localparam logic [2:0] STEP_FULL   = 3'h2;
	// high and low side gate drives of one full bridge
	typedef struct packed {
		logic hs1;
		logic ls1;
		logic hs2;
		logic ls2;
	} sps_bridge_t;
	// winding demand from the phase table
	typedef struct packed {
		logic on;
		logic dir;
	} sps_wind_t;
	localparam sps_bridge_t BRIDGE_OFF = 4'h0;
endpackage
`default_nettype wire

// ===== src/sps_chopper.sv
// constant off-time chopper of one winding
`default_nettype none
module sps_chopper #(
	parameter int TW = sps_pkg::TOFF_W
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// control
	input  wire logic                 enable,
	input  wire logic                 slow_decay,
	input  wire logic [TW-1:0]        toff_cycles,
	// demand and comparator
	input  wire sps_pkg::sps_wind_t   wind,
	input  wire logic                 trip,
	// bridge drive
	output var  sps_pkg::sps_bridge_t bridge,
	output var  logic                 in_off
);
	logic [TW-1:0]        cnt_r;
	logic [TW-1:0]        cnt_nxt;
	sps_pkg::sps_bridge_t drv_on;
	sps_pkg::sps_bridge_t drv_off;
	sps_pkg::sps_bridge_t drv_nxt;

	assign cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 :
		(trip && wind.on) ? toff_cycles : cnt_r;

	// dir high: current from side 1 to side 2
	assign drv_on = !wind.on ? sps_pkg::BRIDGE_OFF :
		wind.dir ? sps_pkg::sps_bridge_t'(4'h9) : sps_pkg::sps_bridge_t'(4'h6);
	assign drv_off = slow_decay ? sps_pkg::sps_bridge_t'(4'hA) :
		wind.dir ? sps_pkg::sps_bridge_t'(4'h4) : sps_pkg::sps_bridge_t'(4'h1);
	assign drv_nxt = (!enable || !wind.on) ? sps_pkg::BRIDGE_OFF :
		(cnt_nxt != '0) ? drv_off : drv_on;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r  <= '0;
			bridge <= sps_pkg::BRIDGE_OFF;
			in_off <= 1'b0;
		end
		else
		begin
			cnt_r  <= enable ? cnt_nxt : '0;
			bridge <= drv_nxt;
			in_off <= enable && (cnt_nxt != '0);
		end
	end
endmodule
`default_nettype wire

// ===== src/sps_top.sv
// stepper phase sequencer with per-winding choppers and AHB-Lite registers
`default_nettype none
module sps_top #(
	parameter int TW = sps_pkg::TOFF_W
) (
	// system
	input  wire logic                 CLK_SYS,
	input  wire logic                 RSTN,
	// AHB-Lite slave
	input  wire logic                 HSEL,
	input  wire logic [7:0]           HADDR,
	input  wire logic [1:0]           HTRANS,
	input  wire logic                 HWRITE,
	input  wire logic [2:0]           HSIZE,
	input  wire logic                 HREADY,
	input  wire logic [31:0]          HWDATA,
	output var  logic [31:0]          HRDATA,
	output var  logic                 HREADYOUT,
	output var  logic                 HRESP,
	// controller pins
	input  wire logic                 STEP_CLK,
	input  wire logic                 DIR_CW,
	input  wire logic                 HALF_SEL,
	input  wire logic                 DECAY_SLOW,
	input  wire logic                 SEQ_RESET_N,
	input  wire logic                 ENABLE,
	// analog comparators
	input  wire logic                 SENSE_TRIP_A,
	input  wire logic                 SENSE_TRIP_B,
	input  wire logic                 OVERCUR,
	// bridge drive
	output var  sps_pkg::sps_bridge_t BRIDGE_A,
	output var  sps_pkg::sps_bridge_t BRIDGE_B,
	// open-drain fault: drive low while OVERCUR is high
	output var  logic                 FAULT_O,
	output var  logic                 FAULT_OE,
	output var  logic [2:0]           PHASE_STATE
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int NP = 9;
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] s1_r;
	logic [NP-1:0] s2_r;
	assign pin_raw = {OVERCUR, SENSE_TRIP_B, SENSE_TRIP_A, ENABLE, SEQ_RESET_N,
		DECAY_SLOW, HALF_SEL, DIR_CW, STEP_CLK};

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_sync
			always_ff @(posedge CLK_SYS or negedge RSTN)
			begin
				if (!RSTN)
				begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
				end
				else
				begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	logic stepclk_s;
	logic dircw_s;
	logic half_s;
	logic slow_s;
	logic sreset_n_s;
	logic en_s;
	logic trip_a_s;
	logic trip_b_s;
	logic ovc_s;
	assign {ovc_s, trip_b_s, trip_a_s, en_s, sreset_n_s, slow_s, half_s, dircw_s,
		stepclk_s} = s2_r;

	////////////////////////////////////////////////////////////////////////////
	// register file
	logic [4:0]    ctrl_r;
	logic [TW-1:0] toff_r;
	logic          ovc_flag_r;
	logic [7:0]    ap_addr_r;
	logic          ap_wr_r;
	logic          ap_rd_r;
	logic          ovc_clr;

	wire addr_phase = HSEL && HREADY && HTRANS[1];
	wire wr_ctrl    = ap_wr_r && (ap_addr_r == sps_pkg::ADDR_CTRL);
	wire wr_status  = ap_wr_r && (ap_addr_r == sps_pkg::ADDR_STATUS);
	wire wr_toff    = ap_wr_r && (ap_addr_r == sps_pkg::ADDR_TOFF);
	// software run bit gates the pin enable
	wire run_en     = ctrl_r[sps_pkg::CTRL_RUN];
	// pins and register bits are or-ed, so either side may select a mode
	wire half_mode  = half_s || ctrl_r[sps_pkg::CTRL_HALF];
	wire cw_mode    = dircw_s || ctrl_r[sps_pkg::CTRL_CW];
	wire slow_mode  = slow_s || ctrl_r[sps_pkg::CTRL_SLOW];
	wire drive_en   = en_s && run_en;
	assign ovc_clr  = wr_status && HWDATA[0];

	logic [2:0]  state_r;
	logic        off_a;
	logic        off_b;
	logic [31:0] rd_nxt;
	assign rd_nxt =
		(ap_addr_r == sps_pkg::ADDR_CTRL)   ? {27'h0000000, ctrl_r} :
		(ap_addr_r == sps_pkg::ADDR_STATUS) ? {24'h000000, off_b, off_a, state_r,
			en_s, FAULT_OE, ovc_flag_r} :
		(ap_addr_r == sps_pkg::ADDR_TOFF)   ? {{(32-TW){1'b0}}, toff_r} : 32'h00000000;

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ap_addr_r <= 8'h00;
			ap_wr_r   <= 1'b0;
			ap_rd_r   <= 1'b0;
			ctrl_r    <= sps_pkg::CTRL_RESET;
			toff_r    <= sps_pkg::TOFF_RESET;
			HRDATA    <= 32'h00000000;
		end
		else
		begin
			ap_addr_r <= HADDR;
			ap_wr_r   <= addr_phase && HWRITE;
			ap_rd_r   <= addr_phase && !HWRITE;
			if (wr_ctrl)
				ctrl_r <= HWDATA[4:0];
			if (wr_toff)
				toff_r <= HWDATA[TW-1:0];
			if (addr_phase && !HWRITE)
				HRDATA <= (HADDR == ap_addr_r) ? rd_nxt : 32'h00000000;
			if (ap_rd_r)
				HRDATA <= rd_nxt;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
		else
		begin
			HREADYOUT <= !(addr_phase && !HWRITE);
			HRESP     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase state machine
	logic step_d_r;
	wire  step_rise = stepclk_s && !step_d_r;
	wire [2:0] stride = half_mode ? sps_pkg::STEP_HALF : sps_pkg::STEP_FULL;
	wire [2:0] state_nxt = cw_mode ? state_r + stride : state_r - stride;

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			step_d_r <= 1'b0;
			state_r  <= sps_pkg::STATE_FIRST;
		end
		else
		begin
			step_d_r <= stepclk_s;
			if (!sreset_n_s)
				state_r <= sps_pkg::STATE_FIRST;
			else if (step_rise)
				state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase decode: index 0 (state 1) is both windings positive
	// decode drive patterns
	sps_pkg::sps_wind_t wa;
	sps_pkg::sps_wind_t wb;
	always_comb
	begin
		wa = '0;
		wb = '0;
		case (state_r)
			3'h0:
			begin
				wa = 2'h3;
				wb = 2'h3;
			end
			3'h1: wb = 2'h3;
			3'h2:
			begin
				wa = 2'h2;
				wb = 2'h3;
			end
			3'h3: wa = 2'h2;
			3'h4:
			begin
				wa = 2'h2;
				wb = 2'h2;
			end
			3'h5: wb = 2'h2;
			3'h6:
			begin
				wa = 2'h3;
				wb = 2'h2;
			end
			3'h7: wa = 2'h3;
			default:
			begin
				wa = '0;
				wb = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// choppers
	// independent per winding
	sps_chopper #(.TW(TW)) u_chop_a (
		.clk         (CLK_SYS),
		.rst_n       (RSTN),
		.enable      (drive_en),
		.slow_decay  (slow_mode),
		.toff_cycles (toff_r),
		.wind        (wa),
		.trip        (trip_a_s),
		.bridge      (BRIDGE_A),
		.in_off      (off_a)
	);
	sps_chopper #(.TW(TW)) u_chop_b (
		.clk         (CLK_SYS),
		.rst_n       (RSTN),
		.enable      (drive_en),
		.slow_decay  (slow_mode),
		.toff_cycles (toff_r),
		.wind        (wb),
		.trip        (trip_b_s),
		.bridge      (BRIDGE_B),
		.in_off      (off_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// overcurrent fault; set wins over software clear
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ovc_flag_r  <= 1'b0;
			FAULT_O     <= 1'b0;
			FAULT_OE    <= 1'b0;
			PHASE_STATE <= sps_pkg::STATE_FIRST;
		end
		else
		begin
			if (ovc_s)
				ovc_flag_r <= 1'b1;
			else if (ovc_clr)
				ovc_flag_r <= 1'b0;
			FAULT_O     <= 1'b0;
			FAULT_OE    <= ovc_s;
			PHASE_STATE <= state_r;
		end
	end
endmodule
`default_nettype wire

// ===== tb/sps_top_assertions.sv
// port-level checks of the stepper sequencer
`default_nettype none
module sps_assertions (
	// system
	input wire logic                 CLK_SYS,
	input wire logic                 RSTN,
	// controller pins and comparators
	input wire logic                 DIR_CW,
	input wire logic                 HALF_SEL,
	input wire logic                 DECAY_SLOW,
	input wire logic                 SEQ_RESET_N,
	input wire logic                 ENABLE,
	input wire logic                 SENSE_TRIP_A,
	input wire logic                 SENSE_TRIP_B,
	input wire logic                 OVERCUR,
	// outputs
	input wire sps_pkg::sps_bridge_t BRIDGE_A,
	input wire sps_pkg::sps_bridge_t BRIDGE_B,
	input wire logic                 FAULT_O,
	input wire logic                 FAULT_OE,
	input wire logic [2:0]           PHASE_STATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	property p_rst;
		!SEQ_RESET_N [*5] |-> PHASE_STATE == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("state not first");
	property p_half;
		SEQ_RESET_N && HALF_SEL && $changed(PHASE_STATE)
			|-> PHASE_STATE == $past(PHASE_STATE) + (DIR_CW ? 3'h1 : 3'h7);
	endproperty
	a_half: assert property (p_half) else $error("half step size");
	property p_full;
		SEQ_RESET_N && !HALF_SEL && $changed(PHASE_STATE)
			|-> PHASE_STATE == $past(PHASE_STATE) + (DIR_CW ? 3'h2 : 3'h6);
	endproperty
	a_full: assert property (p_full) else $error("full step size");
	property p_off;
		!ENABLE [*4] |-> BRIDGE_A == sps_pkg::BRIDGE_OFF && BRIDGE_B == sps_pkg::BRIDGE_OFF;
	endproperty
	a_off: assert property (p_off) else $error("bridge on while disabled");
	property p_flt;
		OVERCUR [*4] |-> FAULT_OE && !FAULT_O;
	endproperty
	a_flt: assert property (p_flt) else $error("fault not pulled");
	property p_slow;
		$rose(SENSE_TRIP_A) && DECAY_SLOW && ENABLE && (BRIDGE_A[2] || BRIDGE_A[0])
			|-> ##[1:5] (BRIDGE_A[3] && BRIDGE_A[1]);
	endproperty
	a_slow: assert property (p_slow) else $error("slow decay");
	property p_fast;
		$rose(SENSE_TRIP_B) && !DECAY_SLOW && ENABLE && (BRIDGE_B[2] || BRIDGE_B[0])
			|-> ##[1:5] (!BRIDGE_B[3] && !BRIDGE_B[1] && (BRIDGE_B[2] ^ BRIDGE_B[0]));
	endproperty
	a_fast: assert property (p_fast) else $error("fast decay");
	property p_wave;
		ENABLE && !HALF_SEL && PHASE_STATE[0] && $stable(PHASE_STATE) && !SENSE_TRIP_A
			&& !SENSE_TRIP_B && (|BRIDGE_A || |BRIDGE_B) |-> (|BRIDGE_A) != (|BRIDGE_B);
	endproperty
	a_wave: assert property (p_wave) else $error("wave drive");
endmodule
bind sps_top sps_assertions sps_assertions_inst (
	.CLK_SYS, .RSTN, .DIR_CW, .HALF_SEL, .DECAY_SLOW, .SEQ_RESET_N, .ENABLE,
	.SENSE_TRIP_A, .SENSE_TRIP_B, .OVERCUR, .BRIDGE_A, .BRIDGE_B, .FAULT_O,
	.FAULT_OE, .PHASE_STATE
);
`default_nettype wire

// ===== tb/sps_ctrl_model.sv
// controller model: step pulses and enable recovery
`default_nettype none
module sps_ctrl_model #(
	parameter int HOLD   = 3,
	parameter int RC_CYC = 30
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// bench requests
	input  wire logic       start,
	input  wire logic [3:0] n,
	input  wire logic       en_req,
	input  wire logic       fault_oe,
	// driver pins
	output var  logic       step_clk,
	output var  logic       enable,
	output var  logic       busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left_r;
	int         ph_r;
	int         rc_r;
	assign busy = left_r != 4'h0;
	// pulses long enough for the pin synchroniser
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_r   <= 4'h0;
			ph_r     <= 0;
			step_clk <= 1'b0;
		end
		else if (start)
		begin
			left_r <= n;
			ph_r   <= 0;
		end
		else if (busy)
		begin
			ph_r     <= (ph_r == 2 * HOLD - 1) ? 0 : ph_r + 1;
			step_clk <= ph_r >= HOLD - 1 && ph_r < 2 * HOLD - 1;
			if (ph_r == 2 * HOLD - 1)
				left_r <= left_r - 4'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rc_r   <= 0;
			enable <= 1'b0;
		end
		else
		begin
			rc_r   <= fault_oe ? RC_CYC : (rc_r > 0 ? rc_r - 1 : 0);
			enable <= en_req && !fault_oe && rc_r == 0;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench of the stepper sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic                 dir = 1'b1, half = 1'b0, slow = 1'b0, srn = 1'b1, en_req = 1'b0;
	logic                 trip_a = 1'b0, trip_b = 1'b0, ocur = 1'b0, go = 1'b0;
	logic                 hready, hresp, step, en, busy, f_o, f_oe;
	logic [7:0]           haddr = 8'h00;
	logic [1:0]           htrans = 2'h0;
	logic [3:0]           nst = 4'h0;
	logic [2:0]           ph;
	logic [31:0]          hwdata = 32'h0, hrdata, rd_s, q;
	sps_pkg::sps_bridge_t br_a, br_b, a0, b0;
	int                   mismatches = 0, n_tests = 0;
	always #50 clk = ~clk;
	sps_top sps_top_inst (
		.CLK_SYS(clk), .RSTN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .STEP_CLK(step), .DIR_CW(dir), .HALF_SEL(half),
		.DECAY_SLOW(slow), .SEQ_RESET_N(srn), .ENABLE(en), .SENSE_TRIP_A(trip_a),
		.SENSE_TRIP_B(trip_b), .OVERCUR(ocur), .BRIDGE_A(br_a), .BRIDGE_B(br_b),
		.FAULT_O(f_o), .FAULT_OE(f_oe), .PHASE_STATE(ph)
	);
	sps_ctrl_model sps_ctrl_model_inst (
		.clk(clk), .rst_n(rst_n), .start(go), .n(nst), .en_req(en_req),
		.fault_oe(f_oe), .step_clk(step), .enable(en), .busy(busy)
	);
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 200)
		begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// ready seen at negedge equals what the next rising edge samples
	task automatic rdy(inout int n);
		logic r;
		do
		begin
			@(negedge clk);
			r = hready;
			rd_s = hrdata;
			@(posedge clk);
			n++;
		end
		while (!r && n < 200);
		tmo(n);
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy(n);
		q = rd_s;
		chk(hresp, 1'b0);
	endtask
	task automatic stp(input logic [3:0] k);
		int n = 0;
		@(posedge clk);
		nst <= k;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (busy && n < 200);
		tmo(n);
		wt(4);
	endtask
	// pins change right after a rising edge, checks look at the falling edge
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wt(1);
		chk(ph, 3'h0);
		bus(sps_pkg::ADDR_TOFF, 1'b0, 32'h0);
		chk(q, 32'h0000_00C8);
		bus(8'h0C, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(sps_pkg::ADDR_TOFF, 1'b1, 32'h0000_0014);
		bus(sps_pkg::ADDR_CTRL, 1'b1, 32'h0000_0010);
		en_req <= 1'b1;
		wt(6);
		chk({|br_a, |br_b}, 2'b11);
		@(posedge clk);
		half <= 1'b1;
		for (int i = 1; i <= 8; i++)
		begin
			stp(4'h1);
			chk(ph, i % 8);
			chk({|br_a, |br_b}, i[0] ? (i[1] ? 2'b10 : 2'b01) : 2'b11);
		end
		@(posedge clk);
		dir <= 1'b0;
		stp(4'h1);
		chk(ph, 3'h7);
		@(posedge clk);
		half <= 1'b0;
		stp(4'h2);
		chk({ph, |br_a, |br_b}, 5'b011_10);
		@(posedge clk);
		srn <= 1'b0;
		wt(4);
		chk(ph, 3'h0);
		@(posedge clk);
		srn <= 1'b1;
		dir <= 1'b1;
		stp(4'h1);
		chk({ph, |br_a, |br_b}, 5'b010_11);
		@(posedge clk);
		slow <= 1'b1;
		wt(5);
		a0 = br_a;
		b0 = br_b;
		// state index 2: A negative (hs2, ls1), B positive (hs1, ls2)
		chk({br_a, br_b}, 8'h69);
		@(posedge clk);
		trip_a <= 1'b1;
		wt(2);
		@(posedge clk);
		trip_a <= 1'b0;
		wt(4);
		chk(br_a, 4'hA);
		chk(br_b, b0);
		// trip lands three edges after the pin: off-time is 20 cycles
		wt(15);
		chk(br_a, 4'hA);
		wt(1);
		chk(br_a, a0);
		@(posedge clk);
		slow <= 1'b0;
		wt(5);
		@(posedge clk);
		trip_b <= 1'b1;
		wt(2);
		@(posedge clk);
		trip_b <= 1'b0;
		wt(4);
		chk(br_b, {1'b0, b0.ls2, 1'b0, b0.ls1});
		chk(br_a, a0);
		@(posedge clk);
		ocur <= 1'b1;
		wt(5);
		chk({f_oe, f_o}, 2'b10);
		@(posedge clk);
		ocur <= 1'b0;
		wt(8);
		chk({br_a, br_b}, 8'h00);
		// recovery waits for the model's rc delay after the fault clears
		wt(25);
		chk(|br_a, 1'b0);
		wt(15);
		chk(|br_a, 1'b1);
		// slow decay chosen by the control register alone
		bus(sps_pkg::ADDR_CTRL, 1'b1, 32'h0000_0014);
		wt(4);
		@(posedge clk);
		trip_a <= 1'b1;
		wt(2);
		@(posedge clk);
		trip_a <= 1'b0;
		wt(4);
		chk(br_a, 4'hA);
		// off a, state 2, enabled, fault gone, sticky overcurrent
		bus(sps_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk(q, 32'h0000_0055);
		bus(sps_pkg::ADDR_STATUS, 1'b1, 32'h1);
		bus(sps_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk(q[0], 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
